// ---- core/internal_osc_tuning.sv ----
// Purpose: Oscillator tuning control register with low-frequency clock source mux
// Assumes: Oscillator edges arrive as asynchronous level toggles on pins
// Notes:   Trim code drives the fast oscillator trim input through one register stage
`timescale 1ns/1ps
module internal_osc_tuning (
  // System
  input  wire logic        CLK,
  input  wire logic        RESETN,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Oscillator sources
  input  wire logic        FAST_OSC_IN,
  input  wire logic        SLOW_RC_IN,
  // Oscillator control and low-frequency output
  output logic [4:0]       FAST_OSC_TRIM,
  output logic [4:0]       SLOW_RC_TRIM,
  output logic             LF_SOURCE_SELECT,
  output logic             LF_TICK
);
  logic [7:0] ctrl_r;
  logic [2:0] fast_sync_r;
  logic [2:0] slow_sync_r;
  logic       fast_lvl_r;
  logic       slow_lvl_r;
  logic       fast_tick;
  logic       slow_tick;
  logic       div_tick;
  logic       lf_nxt;
  logic [7:0] lf_count_r;
  logic       wr_en;
  logic       rd_en;
  logic       addr_ok;

  function automatic logic hit(input logic [11:0] a);
    hit = (a == osc_tune_pkg::TRIM_CTRL_OFFSET) || (a == osc_tune_pkg::STATUS_OFFSET);
  endfunction

  assign addr_ok = hit(PADDR);
  assign wr_en   = PSEL && PENABLE && PWRITE && addr_ok;
  assign rd_en   = PSEL && !PENABLE && !PWRITE && addr_ok;
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;

  always_ff @(posedge CLK)
  begin
    if (!RESETN)
      ctrl_r <= osc_tune_pkg::TRIM_CTRL_RESET;
    else if (wr_en && (PADDR == osc_tune_pkg::TRIM_CTRL_OFFSET) && PSTRB[0])
      ctrl_r <= PWDATA[7:0] & osc_tune_pkg::TRIM_CTRL_MASK;
  end

  // Read data captured in setup phase
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
      PRDATA <= 32'h0000_0000;
    else if (rd_en)
    begin
      if (PADDR == osc_tune_pkg::TRIM_CTRL_OFFSET)
        PRDATA <= {24'h00_0000, ctrl_r};
      else
        PRDATA <= {23'h00_0000, lf_nxt, lf_count_r};
    end
  end

  // Synchronise oscillator levels
  always_ff @(posedge CLK)
  begin
    if (!RESETN)
    begin
      fast_sync_r <= 3'h0;
      slow_sync_r <= 3'h0;
      fast_lvl_r  <= 1'b0;
      slow_lvl_r  <= 1'b0;
    end
    else
    begin
      fast_sync_r <= {fast_sync_r[1:0], FAST_OSC_IN};
      slow_sync_r <= {slow_sync_r[1:0], SLOW_RC_IN};
      if (fast_sync_r[1] == fast_sync_r[2])
        fast_lvl_r <= fast_sync_r[2];
      if (slow_sync_r[1] == slow_sync_r[2])
        slow_lvl_r <= slow_sync_r[2];
    end
  end

  assign fast_tick = (fast_sync_r[1] == fast_sync_r[2]) && fast_sync_r[2] && !fast_lvl_r;
  assign slow_tick = (slow_sync_r[1] == slow_sync_r[2]) && slow_sync_r[2] && !slow_lvl_r;

  lf_divider #(
    .DIV_W (osc_tune_pkg::LF_DIV_W)
  ) u_div (
    .clk      (CLK),
    .resetn   (RESETN),
    .tick_in  (fast_tick),
    .tick_out (div_tick)
  );

  assign lf_nxt = ctrl_r[osc_tune_pkg::SEL_BIT] ? div_tick : slow_tick;

  always_ff @(posedge CLK)
  begin
    if (!RESETN)
      LF_TICK <= 1'b0;
    else
      LF_TICK <= lf_nxt;
  end

  always_ff @(posedge CLK)
  begin
    if (!RESETN)
      lf_count_r <= 8'h00;
    else if (lf_nxt)
      lf_count_r <= lf_count_r + 1'b1;
  end

  always_ff @(posedge CLK)
  begin
    if (!RESETN)
      FAST_OSC_TRIM <= osc_tune_pkg::TRIM_CENTRE;
    else
      FAST_OSC_TRIM <= ctrl_r[osc_tune_pkg::TRIM_MSB:0];
  end

  assign SLOW_RC_TRIM = osc_tune_pkg::TRIM_CENTRE;

  always_ff @(posedge CLK)
  begin
    if (!RESETN)
      LF_SOURCE_SELECT <= 1'b0;
    else
      LF_SOURCE_SELECT <= ctrl_r[osc_tune_pkg::SEL_BIT];
  end
endmodule

// ---- core/osc_tune_pkg.sv ----
// Purpose: Constants for the oscillator tuning control block
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes:   Clock is 125 MHz
package osc_tune_pkg;
  localparam logic [11:0] TRIM_CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET    = 12'h004;
  localparam int          SEL_BIT          = 7;
  localparam int          TRIM_MSB         = 4;
  localparam int          TRIM_W           = 5;
  localparam logic [7:0]  TRIM_CTRL_RESET  = 8'h00;
  localparam logic [7:0]  TRIM_CTRL_MASK   = 8'h9f;
  localparam int          LF_DIV           = 256;
  localparam int          LF_DIV_W         = 8;
  localparam logic [4:0]  TRIM_CENTRE      = 5'h00;
  localparam int          SYNC_STAGES      = 3;
endpackage

// ---- core/lf_divider.sv ----
// Purpose: Divide the fast oscillator tick stream down to the low-frequency tick
// Assumes: Input tick is a one-cycle pulse on CLK
// Notes:   Emits one pulse per DIV input pulses
`timescale 1ns/1ps
module lf_divider #(
  parameter int DIV_W = 8
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic tick_in,
  output logic      tick_out
);
  logic [DIV_W-1:0] cnt_r;

  always_ff @(posedge clk)
  begin
    if (!resetn)
      cnt_r <= '0;
    else if (tick_in)
      cnt_r <= cnt_r + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      tick_out <= 1'b0;
    else
      tick_out <= tick_in && (&cnt_r);
  end
endmodule

// ---- tb/osc_model.sv ----
// Purpose: Oscillator pair model
// Assumes: Free-running sources
// Notes:   Fast rate follows trim
`timescale 1ns/1ps
module osc_model (
  // Trim in, clocks out
  input  logic [4:0] trim,
  output logic       fast,
  output logic       slow
);
  initial {fast, slow} = 2'b00;
  always #(20.0 - ($isunknown(trim) ? 0.0 : $signed(trim) / 4.0)) fast = ~fast;
  always #400 slow = ~slow;
endmodule

// ---- tb/osc_tune_checker.sv ----
// Purpose: Port checks
// Assumes: Zero-wait bus
// Notes:   Bound below
`timescale 1ns/1ps
module osc_tune_checker (
  // Bus
  input logic        CLK,
  input logic        RESETN,
  input logic        PSEL,
  input logic        PENABLE,
  input logic        PWRITE,
  input logic [11:0] PADDR,
  input logic [31:0] PWDATA,
  input logic [31:0] PRDATA,
  // Clock source, trims, source select and tick
  input logic        SLOW_RC_IN,
  input logic [4:0]  FAST_OSC_TRIM,
  input logic [4:0]  SLOW_RC_TRIM,
  input logic        LF_SOURCE_SELECT,
  input logic        LF_TICK
);
  wire on0 = PSEL && PADDR == 12'h000;
  wire wr = on0 && PENABLE && PWRITE;
  sequence rd_cyc;
    on0 && !PENABLE && !PWRITE ##1 on0 && PENABLE;
  endsequence
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  sel_write_a: assert property (wr |=> ##1 (LF_SOURCE_SELECT == $past(PWDATA[7], 2)))
    else $error("bad select");
  slow_tick_a: assert property ($rose(SLOW_RC_IN) && !LF_SOURCE_SELECT
    |-> ##[1:6] (LF_TICK || LF_SOURCE_SELECT)) else $error("no slow tick");
  tick_pulse_a: assert property (LF_TICK |=> !LF_TICK)
    else $error("long tick");
  read_back_a: assert property (rd_cyc |-> PRDATA[7:0] == {LF_SOURCE_SELECT, 2'b00, FAST_OSC_TRIM})
    else $error("bad read");
  trim_write_a: assert property (wr |=> ##1 (FAST_OSC_TRIM == $past(PWDATA[4:0], 2)))
    else $error("bad trim");
  trim_hold_a: assert property (!wr |=> ##1 $stable(FAST_OSC_TRIM))
    else $error("trim moved");
  trim_reset_a: assert property ($rose(RESETN) |-> FAST_OSC_TRIM == 5'h00)
    else $error("bad reset trim");
  slow_trim_a: assert property (SLOW_RC_TRIM == 5'h00)
    else $error("slow trimmed");
endmodule
bind internal_osc_tuning osc_tune_checker chk (.*);

// ---- tb/internal_osc_tuning_tb.sv ----
// Purpose: Register and clock tests
// Assumes: Zero-wait bus
// Notes:   Ticks counted at the port
`timescale 1ns/1ps
module internal_osc_tuning_tb;
  logic CLK, RESETN, PSEL, PENABLE, PWRITE, FAST_OSC_IN, SLOW_RC_IN, PREADY, LF_TICK;
  logic PSLVERR, rerr;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rdat;
  logic [4:0]  FAST_OSC_TRIM;
  logic [7:0]  tbl [5] = '{8'h6f, 8'hf0, 8'h7f, 8'he1, 8'h60};
  int          miscompares = 0, checks = 0, ticks = 0, t0;
  internal_osc_tuning dut (.CLK, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PSTRB(4'hf), .PRDATA, .PREADY, .PSLVERR, .FAST_OSC_IN, .SLOW_RC_IN,
    .FAST_OSC_TRIM, .SLOW_RC_TRIM(), .LF_SOURCE_SELECT(), .LF_TICK);
  osc_model osc (.trim(FAST_OSC_TRIM), .fast(FAST_OSC_IN), .slow(SLOW_RC_IN));
  initial
  begin
    CLK = 0;
    forever #4 CLK = ~CLK;
  end
  always @(posedge CLK) ticks <= ticks + (LF_TICK === 1'b1);
  task automatic chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, a, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rdat = PRDATA;
    rerr = PSLVERR;
    {PSEL, PENABLE} <= 2'b00;
  endtask
  task automatic give_verdict;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #100000;
    miscompares++;
    give_verdict;
  end
  initial
  begin
    {RESETN, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    repeat (4) @(posedge CLK);
    RESETN <= 1'b1;
    xfer(0, 12'h000, 32'h0);
    chk(rdat, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      xfer(1, 12'h000, {24'hffffff, tbl[i]});
      xfer(1, 12'h008, 32'h0);
      chk(rerr, 1);
      xfer(0, 12'h000, 32'h0);
      chk(rdat, {24'h0, tbl[i] & 8'h9f});
      chk(FAST_OSC_TRIM, tbl[i][4:0]);
    end
    t0 = ticks;
    repeat (1000) @(posedge CLK);
    chk(ticks - t0 inside {[9:11]}, 1);
    xfer(1, 12'h000, 32'h80);
    t0 = ticks;
    repeat (2600) @(posedge CLK);
    chk(ticks - t0 inside {[1:3]}, 1);
    give_verdict;
  end
endmodule
